// file: byte_fifo.sv
`timescale 1ns/1ps
// depth must be a power of two: pointers wrap by overflow
module byte_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              empty
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = D[AW:0];

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          wr;
  logic          rd;

  assign in_ready  = cnt_ff != FULL_CNT;
  assign empty     = cnt_ff == '0;
  assign out_valid = !empty;
  assign out_data  = mem_q[rp_ff];
  assign wr        = ce && in_valid && in_ready;
  assign rd        = ce && out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (wr) begin
      mem_q[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (wr) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (rd) begin
        rp_ff <= rp_ff + 1'b1;
      end
      if (wr && !rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (rd && !wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// file: i2c_dual_pkg.sv
package i2c_dual_pkg;
  localparam int          STRAP_W       = 6;
  localparam int          SYNC_W        = 9;
  localparam logic [8:0]  SYNC_RST      = 9'h180;
  localparam int          SYNC_SCL      = 7;
  localparam int          SYNC_SDA      = 8;
  localparam logic [6:0]  IO_BASE_ADDR  = 7'h20;
  localparam logic [6:0]  MEM_BASE_ADDR = 7'h50;
  localparam logic [2:0]  FULL_STRAP    = 3'h6;
  localparam logic [5:0]  PAGE_LAST     = 6'h3F;
  localparam logic [15:0] MEM_LAST_DFLT = 16'h6FFF;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [7:0]  HI_MASK       = 8'h7F;
  localparam logic [3:0]  BIT_LAST      = 4'h8;
  localparam logic [3:0]  TX_LAST       = 4'h7;
  localparam logic [1:0]  IDX_DATA      = 2'h2;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          FIFO_W        = 24;

  typedef enum logic [5:0] {
    st_idle  = 6'h01,
    st_rx    = 6'h02,
    st_ack   = 6'h04,
    st_tx    = 6'h08,
    st_txack = 6'h10,
    st_hold  = 6'h20
  } st_t;

  typedef enum logic [1:0] {
    tgt_undec = 2'h0,
    tgt_io    = 2'h1,
    tgt_mem   = 2'h2
  } tgt_t;
endpackage

// file: i2c_dual_target.sv
`timescale 1ns/1ps
module i2c_dual_target #(
  parameter logic [15:0] MEM_LAST = i2c_dual_pkg::MEM_LAST_DFLT
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        base_strap_bit,
  input  wire logic [5:0]  extension_strap_bits,
  input  wire logic [2:0]  strap_count,
  output logic             io_cmd_valid,
  output logic [7:0]       io_cmd,
  output logic             io_wdata_valid,
  output logic [7:0]       io_wdata,
  output logic             rd_req,
  output logic             rd_mem,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_ack,
  output logic             prog_valid,
  input  wire logic        prog_ready,
  output logic [15:0]      prog_addr,
  output logic [7:0]       prog_data,
  input  wire logic        prog_busy
);
  logic [8:0]                s1_ff;
  logic [8:0]                s2_ff;
  logic [8:0]                s3_ff;
  logic [8:0]                filt_ff;
  logic [8:0]                pins;
  logic                      scl_f;
  logic                      sda_f;
  logic                      scl_d_ff;
  logic                      sda_d_ff;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_c;
  logic                      stop_c;
  i2c_dual_pkg::st_t         st_ff;
  i2c_dual_pkg::tgt_t        tgt_ff;
  logic [3:0]                bit_ff;
  logic [7:0]                sh_ff;
  logic [7:0]                hi_ff;
  logic [15:0]               addr_ff;
  logic [1:0]                idx_ff;
  logic                      is_addr_ff;
  logic                      rd_ff;
  logic                      ack_ff;
  logic                      mack_ff;
  logic                      pend_ff;
  logic                      commit_ff;
  logic                      fetch_ff;
  logic [6:0]                io_a;
  logic [6:0]                mem_a;
  logic                      full_strap;
  logic                      hit_io;
  logic                      hit_mem;
  logic                      byte_end;
  logic                      wr_ok;
  logic                      push;
  logic                      fifo_ready;
  logic                      fifo_empty;
  logic [15:0]               lo_addr;
  logic [15:0]               fifo_addr;

  // pins are asynchronous: three stages, a change is taken once stages two and three agree
  assign pins = {sda_in, scl_in, extension_strap_bits, base_strap_bit};
  for (genvar g = 0; g < i2c_dual_pkg::SYNC_W; g++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        s1_ff[g]   <= i2c_dual_pkg::SYNC_RST[g];
        s2_ff[g]   <= i2c_dual_pkg::SYNC_RST[g];
        s3_ff[g]   <= i2c_dual_pkg::SYNC_RST[g];
        filt_ff[g] <= i2c_dual_pkg::SYNC_RST[g];
      end else if (ce) begin
        s1_ff[g] <= pins[g];
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        if (s2_ff[g] == s3_ff[g]) begin
          filt_ff[g] <= s3_ff[g];
        end
      end
    end
  end

  assign scl_f = filt_ff[i2c_dual_pkg::SYNC_SCL];
  assign sda_f = filt_ff[i2c_dual_pkg::SYNC_SDA];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (ce) begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
    end
  end

  assign scl_rise = scl_f && !scl_d_ff;
  assign scl_fall = !scl_f && scl_d_ff;
  assign start_c  = scl_f && scl_d_ff && sda_d_ff && !sda_f;
  assign stop_c   = scl_f && scl_d_ff && !sda_d_ff && sda_f;

  // address decode: base strap sets bit 0, extension straps overwrite fixed bits from bit 1 upward
  always_comb begin
    io_a     = i2c_dual_pkg::IO_BASE_ADDR;
    mem_a    = i2c_dual_pkg::MEM_BASE_ADDR;
    io_a[0]  = filt_ff[0];
    mem_a[0] = filt_ff[0];
    for (int i = 0; i < i2c_dual_pkg::STRAP_W; i++) begin
      if (3'(i) < strap_count) begin
        io_a[i+1]  = filt_ff[i+1];
        mem_a[i+1] = filt_ff[i+1];
      end
    end
  end

  assign full_strap = strap_count >= i2c_dual_pkg::FULL_STRAP;
  assign hit_io     = sh_ff[7:1] == io_a;
  assign hit_mem    = sh_ff[7:1] == mem_a;
  assign byte_end   = ce && st_ff == i2c_dual_pkg::st_rx && scl_fall
                      && bit_ff == i2c_dual_pkg::BIT_LAST;
  assign wr_ok      = !is_addr_ff && idx_ff == i2c_dual_pkg::IDX_DATA
                      && tgt_ff == i2c_dual_pkg::tgt_mem && addr_ff <= MEM_LAST;
  // a full buffer stalls the byte in the ack slot with SCL held low
  assign push       = ce && fifo_ready && ((byte_end && wr_ok)
                      || (st_ff == i2c_dual_pkg::st_hold && pend_ff));
  assign lo_addr    = {hi_ff, sh_ff};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff          <= i2c_dual_pkg::st_idle;
      tgt_ff         <= i2c_dual_pkg::tgt_io;
      bit_ff         <= '0;
      sh_ff          <= '0;
      hi_ff          <= '0;
      addr_ff        <= i2c_dual_pkg::ADDR_RST;
      idx_ff         <= '0;
      is_addr_ff     <= 1'b0;
      rd_ff          <= 1'b0;
      ack_ff         <= 1'b0;
      mack_ff        <= 1'b0;
      pend_ff        <= 1'b0;
      commit_ff      <= 1'b0;
      fetch_ff       <= 1'b0;
      io_cmd_valid   <= 1'b0;
      io_cmd         <= '0;
      io_wdata_valid <= 1'b0;
      io_wdata       <= '0;
    end else if (ce) begin
      io_cmd_valid   <= 1'b0;
      io_wdata_valid <= 1'b0;
      if (push) begin
        addr_ff <= addr_ff + 16'h1;
        pend_ff <= 1'b0;
        if (addr_ff[5:0] == i2c_dual_pkg::PAGE_LAST) begin
          commit_ff <= 1'b1;
        end
      end
      if (start_c) begin
        st_ff      <= i2c_dual_pkg::st_rx;
        bit_ff     <= '0;
        is_addr_ff <= 1'b1;
      end else if (stop_c) begin
        st_ff <= i2c_dual_pkg::st_idle;
      end else begin
        unique case (st_ff)
          i2c_dual_pkg::st_idle: begin
          end
          i2c_dual_pkg::st_rx: begin
            if (scl_rise) begin
              sh_ff  <= {sh_ff[6:0], sda_f};
              bit_ff <= bit_ff + 4'h1;
            end else if (byte_end) begin
              is_addr_ff <= 1'b0;
              if (is_addr_ff) begin
                if (hit_io || hit_mem) begin
                  st_ff  <= i2c_dual_pkg::st_ack;
                  ack_ff <= 1'b1;
                  rd_ff  <= sh_ff[0];
                  idx_ff <= '0;
                  if (!full_strap) begin
                    tgt_ff <= hit_io ? i2c_dual_pkg::tgt_io : i2c_dual_pkg::tgt_mem;
                  end else if (!sh_ff[0]) begin
                    tgt_ff <= i2c_dual_pkg::tgt_undec;
                  end
                end else begin
                  st_ff <= i2c_dual_pkg::st_idle;
                end
              end else begin
                st_ff  <= i2c_dual_pkg::st_ack;
                ack_ff <= 1'b1;
                if (idx_ff != i2c_dual_pkg::IDX_DATA) begin
                  idx_ff <= idx_ff + 2'h1;
                end
                if (idx_ff == '0 && (tgt_ff == i2c_dual_pkg::tgt_io
                    || (tgt_ff == i2c_dual_pkg::tgt_undec && !sh_ff[7]))) begin
                  tgt_ff       <= i2c_dual_pkg::tgt_io;
                  io_cmd_valid <= 1'b1;
                  io_cmd       <= sh_ff;
                end else if (idx_ff == '0) begin
                  tgt_ff <= i2c_dual_pkg::tgt_mem;
                  hi_ff  <= (tgt_ff == i2c_dual_pkg::tgt_undec)
                            ? (sh_ff & i2c_dual_pkg::HI_MASK) : sh_ff;
                end else if (tgt_ff == i2c_dual_pkg::tgt_io) begin
                  io_wdata_valid <= 1'b1;
                  io_wdata       <= sh_ff;
                end else if (idx_ff == 2'h1) begin
                  addr_ff <= lo_addr;
                  ack_ff  <= lo_addr <= MEM_LAST;
                end else if (addr_ff > MEM_LAST) begin
                  ack_ff <= 1'b0;
                end else if (!push) begin
                  pend_ff <= 1'b1;
                  st_ff   <= i2c_dual_pkg::st_hold;
                end else if (addr_ff[5:0] == i2c_dual_pkg::PAGE_LAST) begin
                  st_ff <= i2c_dual_pkg::st_hold;
                end
              end
            end
          end
          i2c_dual_pkg::st_ack: begin
            if (scl_fall) begin
              if (!ack_ff) begin
                st_ff <= i2c_dual_pkg::st_idle;
              end else if (rd_ff) begin
                st_ff    <= i2c_dual_pkg::st_hold;
                fetch_ff <= 1'b1;
              end else begin
                st_ff  <= i2c_dual_pkg::st_rx;
                bit_ff <= '0;
              end
            end
          end
          i2c_dual_pkg::st_hold: begin
            if (fetch_ff) begin
              if (rd_ack) begin
                sh_ff    <= rd_data;
                fetch_ff <= 1'b0;
                bit_ff   <= '0;
                st_ff    <= i2c_dual_pkg::st_tx;
              end
            end else if (!pend_ff && !(commit_ff && (!fifo_empty || prog_busy))) begin
              st_ff <= i2c_dual_pkg::st_ack;
              if (commit_ff && !push) begin
                commit_ff <= 1'b0;
              end
            end
          end
          i2c_dual_pkg::st_tx: begin
            if (scl_fall) begin
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == i2c_dual_pkg::TX_LAST) begin
                st_ff <= i2c_dual_pkg::st_txack;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
              end
            end
          end
          i2c_dual_pkg::st_txack: begin
            if (scl_rise) begin
              mack_ff <= !sda_f;
            end else if (scl_fall) begin
              if (mack_ff) begin
                st_ff    <= i2c_dual_pkg::st_hold;
                fetch_ff <= 1'b1;
                // saturates on the last location rather than wrapping
                if (tgt_ff == i2c_dual_pkg::tgt_mem && addr_ff < MEM_LAST) begin
                  addr_ff <= addr_ff + 16'h1;
                end
              end else begin
                st_ff <= i2c_dual_pkg::st_idle;
              end
            end
          end
        endcase
      end
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = st_ff == i2c_dual_pkg::st_hold;
  assign sda_oe  = (((st_ff == i2c_dual_pkg::st_ack) || (st_ff == i2c_dual_pkg::st_hold
                    && !fetch_ff)) && ack_ff) || (st_ff == i2c_dual_pkg::st_tx && !sh_ff[7]);
  assign rd_req  = st_ff == i2c_dual_pkg::st_hold && fetch_ff;
  assign rd_mem  = tgt_ff == i2c_dual_pkg::tgt_mem;
  assign rd_addr = addr_ff;
  assign prog_addr = fifo_addr;

  byte_fifo #(
    .W (i2c_dual_pkg::FIFO_W),
    .D (i2c_dual_pkg::FIFO_DEPTH)
  ) i_byte_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({addr_ff, sh_ff}),
    .out_valid (prog_valid),
    .out_ready (prog_ready),
    .out_data  ({fifo_addr, prog_data}),
    .empty     (fifo_empty)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_drained;
    ce && st_ff == i2c_dual_pkg::st_hold && !fetch_ff && !pend_ff && commit_ff
      && fifo_empty && !prog_busy && !push;
  endsequence
  sequence s_released;
    !commit_ff && !scl_oe && st_ff == i2c_dual_pkg::st_ack;
  endsequence

  property p_io_base;
    (byte_end && is_addr_ff && strap_count == 3'h0
      && sh_ff[7:1] == {i2c_dual_pkg::IO_BASE_ADDR[6:1], filt_ff[0]}) |=> sda_oe;
  endproperty
  a_io_base: assert property (p_io_base) else $error("base io address not acked");
  property p_strap_one;
    (byte_end && is_addr_ff && strap_count == 3'h1
      && sh_ff[7:1] == {i2c_dual_pkg::MEM_BASE_ADDR[6:2], filt_ff[1:0]})
      |=> sda_oe && tgt_ff == i2c_dual_pkg::tgt_mem;
  endproperty
  a_strap_one: assert property (p_strap_one) else $error("strapped address missed");
  property p_ptr_sel;
    (byte_end && !is_addr_ff && idx_ff == '0 && tgt_ff == i2c_dual_pkg::tgt_undec && !sh_ff[7])
      |=> io_cmd_valid && io_cmd == $past(sh_ff);
  endproperty
  a_ptr_sel: assert property (p_ptr_sel) else $error("pointer byte not steered");
  property p_hi_mask;
    (byte_end && !is_addr_ff && idx_ff == '0 && tgt_ff == i2c_dual_pkg::tgt_undec && sh_ff[7])
      |=> !hi_ff[7] && hi_ff[6:0] == $past(sh_ff[6:0]) && !io_cmd_valid;
  endproperty
  a_hi_mask: assert property (p_hi_mask) else $error("high byte not masked");
  property p_addr_load;
    (byte_end && !is_addr_ff && idx_ff == 2'h1 && tgt_ff == i2c_dual_pkg::tgt_mem)
      |=> addr_ff == $past(lo_addr);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address counter not loaded");
  property p_rd_inc;
    (ce && st_ff == i2c_dual_pkg::st_txack && scl_fall && mack_ff
      && tgt_ff == i2c_dual_pkg::tgt_mem && addr_ff < MEM_LAST)
      |=> addr_ff == $past(addr_ff) + 16'h1 && rd_req;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("read address not advanced");
  property p_end_nak;
    (byte_end && !is_addr_ff && idx_ff == i2c_dual_pkg::IDX_DATA
      && tgt_ff == i2c_dual_pkg::tgt_mem && addr_ff > MEM_LAST) |-> !push ##1 !sda_oe;
  endproperty
  a_end_nak: assert property (p_end_nak) else $error("write past end acked");
  property p_stretch;
    (ce && commit_ff && st_ff == i2c_dual_pkg::st_hold && !fetch_ff && !start_c && !stop_c
      && (!fifo_empty || prog_busy)) |=> scl_oe && commit_ff;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock released while programming");
  property p_release;
    s_drained |=> s_released;
  endproperty
  a_release: assert property (p_release) else $error("clock not released");
  property p_cmd_first;
    (byte_end && !is_addr_ff && idx_ff == '0 && tgt_ff == i2c_dual_pkg::tgt_io)
      |=> io_cmd_valid ##1 !io_cmd_valid;
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("command byte not flagged");
  property p_wr_inc;
    push |=> addr_ff == $past(addr_ff) + 16'h1;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("write address not advanced");
  property p_foreign;
    (byte_end && is_addr_ff && !hit_io && !hit_mem) |=> !sda_oe && st_ff == i2c_dual_pkg::st_idle;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address answered");
endmodule

// file: i2c_master_model.sv
`timescale 1ns/1ps
// bus master on the far side; the lines are wired-and with pull-ups in the bench
module i2c_master_model #(
  parameter int Q = 10
) (
  input  wire logic mclk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      m_scl,
  output logic      m_sda
);
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic qw();
    repeat (Q) @(posedge mclk);
    #1;
  endtask
  // release scl, then wait out any stretch; bounded so a stuck line cannot hang
  task automatic rise();
    int n = 0;
    m_scl = 1'b1;
    while (!scl_line && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    #1;
    qw();
  endtask
  // also serves as repeated start
  task automatic start();
    m_sda = 1'b1;
    qw();
    rise();
    m_sda = 1'b0;
    qw();
    m_scl = 1'b0;
    qw();
  endtask
  task automatic stop();
    m_sda = 1'b0;
    qw();
    rise();
    m_sda = 1'b1;
    qw();
  endtask
  // sda only moves a quarter bit after scl fell, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    m_sda = b;
    qw();
    rise();
    r = sda_line;
    qw();
    m_scl = 1'b0;
    qw();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// file: tb_i2c_dual_target.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_i2c_dual_target;
  logic        mclk, rst_b, base_bit, m_scl, m_sda, rd_ack, saw_stretch;
  logic        scl_oe, scl_out, sda_oe, sda_out, rd_req, rd_mem, prog_valid;
  logic        io_cmd_valid, io_wdata_valid, prog_busy, prog_ready;
  logic [5:0]  ext, busy_cnt;
  logic [2:0]  strap_count;
  logic [7:0]  rd_data, io_cmd, io_wdata, got_cmd, got_wd;
  logic [15:0] rd_addr, prog_addr;
  logic [7:0]  prog_data;
  logic [23:0] prog_q[$];
  int          mismatches, samples_checked;
  wire scl = m_scl & (scl_oe ? scl_out : 1'b1);
  wire sda = m_sda & (sda_oe ? sda_out : 1'b1);
  assign prog_busy = busy_cnt != 6'h00;
  assign prog_ready = !prog_busy;

  i2c_dual_target i_i2c_dual_target (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .base_strap_bit(base_bit), .extension_strap_bits(ext), .strap_count(strap_count),
    .io_cmd_valid(io_cmd_valid), .io_cmd(io_cmd), .io_wdata_valid(io_wdata_valid),
    .io_wdata(io_wdata), .rd_req(rd_req), .rd_mem(rd_mem), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ack(rd_ack), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_addr(prog_addr), .prog_data(prog_data), .prog_busy(prog_busy));
  i2c_master_model i_i2c_master_model (.mclk(mclk), .scl_line(scl), .sda_line(sda),
    .m_scl(m_scl), .m_sda(m_sda));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // read source answers one cycle late; programmer is busy 40 cycles after a page end
  always @(posedge mclk) begin
    rd_ack <= #1 rd_req && !rd_ack;
    rd_data <= #1 rd_mem ? (rd_addr[7:0] ^ 8'h5A) : 8'hC3;
    if (prog_valid && prog_ready) prog_q.push_back({prog_addr, prog_data});
    if (prog_valid && prog_ready && prog_addr[5:0] == 6'h3F) busy_cnt <= #1 6'h28;
    else if (prog_busy) busy_cnt <= #1 busy_cnt - 6'h01;
    if (scl_oe && prog_busy) saw_stretch <= 1'b1;
    if (io_cmd_valid) got_cmd <= io_cmd;
    if (io_wdata_valid) got_wd <= io_wdata;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic settle();
    repeat (20) @(posedge mclk);
    #1;
  endtask
  function automatic logic [6:0] tgt_addr(input logic [6:0] fixed, input int n);
    logic [6:0] a;
    a = fixed;
    for (int i = 0; i < n; i++) a[i+1] = ext[i];
    a[0] = base_bit;
    return a;
  endfunction
  task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte({a, rw}, ack);
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    logic ack;
    addr(a, 1'b0, ack);
    i_i2c_master_model.stop();
    `CHK("addr ack", e, ack)
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    logic ack;
    i_i2c_master_model.wbyte(d, ack);
    `CHK("byte ack", e, ack)
  endtask
  task automatic wait_prog(input int cnt);
    int n = 0;
    while (prog_q.size() < cnt && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK("prog count", cnt, prog_q.size())
  endtask
  task automatic chk_word(input logic [23:0] e);
    logic [23:0] w;
    w = prog_q.pop_front();
    `CHK("prog word", e, w)
  endtask

  task automatic t_addr();
    ext = 6'h2D;
    base_bit = 1'b1;
    for (int n = 0; n <= 5; n++) begin
      strap_count = n[2:0];
      settle();
      probe(tgt_addr(7'h20, n), 1'b1);
      probe(tgt_addr(7'h50, n), 1'b1);
      probe(tgt_addr(7'h20, n) ^ 7'h40, n == 5);
      probe(tgt_addr(7'h50, n) ^ 7'h01, 1'b0);
    end
    $display("test addressing done");
  endtask
  // unaligned block write crossing a 64-byte boundary
  task automatic t_mem_write();
    logic ack;
    logic [7:0] d;
    strap_count = 3'h0;
    settle();
    addr(7'h21, 1'b0, ack);
    wb(8'h05, 1'b1);
    wb(8'h99, 1'b1);
    addr(7'h21, 1'b1, ack);
    i_i2c_master_model.rbyte(1'b1, d);
    i_i2c_master_model.stop();
    `CHK("io pointer", 8'h05, got_cmd)
    `CHK("io data", 8'h99, got_wd)
    `CHK("io read", 8'hC3, d)
    addr(7'h51, 1'b0, ack);
    wb(8'h01, 1'b1);
    wb(8'h3E, 1'b1);
    for (int i = 0; i < 3; i++) wb(8'(8'hD0 + i), 1'b1);
    i_i2c_master_model.stop();
    wait_prog(3);
    for (int i = 0; i < 3; i++) chk_word({16'(16'h013E + i), 8'(8'hD0 + i)});
    `CHK("stretch seen", 1'b1, saw_stretch)
    $display("test memory write done");
  endtask
  task automatic t_mem_read();
    logic ack;
    logic [7:0] d;
    addr(7'h51, 1'b0, ack);
    wb(8'h6F, 1'b1);
    wb(8'hFD, 1'b1);
    addr(7'h51, 1'b1, ack);
    `CHK("read ack", 1'b1, ack)
    for (int i = 0; i < 4; i++) begin
      i_i2c_master_model.rbyte(i == 3, d);
      `CHK("read data", (i < 2 ? 8'hFD + 8'(i) : 8'hFF) ^ 8'h5A, d)
    end
    i_i2c_master_model.stop();
    $display("test memory read done");
  endtask
  task automatic t_mem_end();
    logic ack;
    addr(7'h51, 1'b0, ack);
    i_i2c_master_model.wbyte(8'h70, ack);
    wb(8'h00, 1'b0);
    i_i2c_master_model.stop();
    addr(7'h51, 1'b0, ack);
    wb(8'h6F, 1'b1);
    wb(8'hFF, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b0);
    i_i2c_master_model.stop();
    settle();
    wait_prog(1);
    chk_word({16'h6FFF, 8'h11});
    $display("test memory end done");
  endtask
  task automatic t_full();
    logic ack;
    strap_count = 3'h6;
    ext = 6'h33;
    base_bit = 1'b0;
    settle();
    addr(tgt_addr(7'h20, 6), 1'b0, ack);
    wb(8'h15, 1'b1);
    wb(8'hA7, 1'b1);
    i_i2c_master_model.stop();
    `CHK("io pointer", 8'h15, got_cmd)
    `CHK("io data", 8'hA7, got_wd)
    addr(tgt_addr(7'h20, 6), 1'b0, ack);
    wb(8'h81, 1'b1);
    wb(8'h20, 1'b1);
    wb(8'h77, 1'b1);
    i_i2c_master_model.stop();
    wait_prog(1);
    chk_word({16'h0120, 8'h77});
    $display("test full strap done");
  endtask

  initial begin
    mismatches = 0;
    samples_checked = 0;
    repeat (50000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  initial begin
    {rst_b, base_bit, rd_ack, saw_stretch} = 4'h0;
    {ext, strap_count, busy_cnt, rd_data, got_cmd, got_wd} = 39'h0;
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_addr();
    t_mem_write();
    t_mem_read();
    t_mem_end();
    t_full();
    test_done();
  end
endmodule
